// file: dv/tas_cipher_model.sv
// Purpose: Behavioural shared cipher core facing the signer
// Assumes: Request valid is a level, answer is a one-cycle ack
// Notes: Latency is one cycle, or random up to six when slow is high
`timescale 1ns/1ps
`default_nettype none

module tas_cipher_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic slow,
    input wire tas_pkg::tas_aes_req_type aes_req,
    output var tas_pkg::tas_aes_rsp_type aes_rsp
);
    logic busy; // An operation is in flight
    int cnt; // Cycles left before the answer
    logic [127:0] blk; // Block taken at the start
    logic [127:0] key; // Key taken at the start

    // Never start in the ack cycle: the signer swaps the block on that edge
    always @(posedge sys_clk) begin
        if (reset) begin
            busy <= 1'b0;
            aes_rsp <= '0;
        end else if (aes_rsp.ack) begin
            aes_rsp.ack <= 1'b0;
            aes_rsp.result <= ~aes_rsp.result; // Stale result must not linger
        end else if (busy) begin
            if (cnt <= 1) begin
                aes_rsp.ack <= 1'b1;
                aes_rsp.result <= tas_dv_pkg::cipher(blk, key);
                busy <= 1'b0;
            end else begin
                cnt <= cnt - 1;
            end
        end else begin
            aes_rsp.result <= ~aes_rsp.result;
            if (aes_req.valid) begin
                busy <= 1'b1;
                blk <= aes_req.block;
                key <= aes_req.key;
                cnt <= slow ? 1 + int'($urandom() % 6) : 1;
            end
        end
    end

endmodule : tas_cipher_model

`default_nettype wire

// file: dv/tas_dv_pkg.sv
// Purpose: Stand-in block cipher shared by the core model and the bench
// Assumes: Only the signer's sequencing is under test, not the cipher
// Notes: Three fixed answers for the reference key, a toy mix elsewhere
package tas_dv_pkg;

    // Reference key whose three cipher answers are known
    localparam logic [127:0] doc_key = 128'h3DDA31AD44767AE3CE56DCE2B3CE2ABB;

    // Toy mix is cheap but keeps byte positions apart, so swaps still show
    function automatic logic [127:0] cipher(input logic [127:0] b, input logic [127:0] k);
        if (k == doc_key) begin
            case (b)
                128'h49B819000015E25D0400000000000000: return 128'h41EF09792AE152AE52C671435C1F247D;
                128'h41E6058670BB0FAA52C660435C1F247D: return 128'h8D89E733DA516AE3E08F9E30184909FC;
                128'h01B819000015E25D0400000000000000: return 128'h3F736FCC8BCAF2D4AABCA0260FAB7976;
                default: ;
            endcase
        end
        return {b[95:0], b[127:96]} ^ k ^ 128'hA55A3CC3A55A3CC3A55A3CC3A55A3CC3;
    endfunction : cipher

endpackage : tas_dv_pkg

// file: dv/tas_signer_bench.sv
// Purpose: Self-checking bench for the telegram signer
// Assumes: Inputs change at the falling edge; cipher is the dv stand-in
// Notes: Drivers queue expectations, a watcher pops them on each result
`timescale 1ns/1ps
`default_nettype none
`include "tas_regs.svh"

module tas_signer_bench;
    logic sys_clk, reset, slow;
    logic start_send, start_repeat, start_verify, commission_req, disable_commission;
    logic key_wr_en;
    logic [3:0] key_wr_idx;
    logic [7:0] key_wr_byte;
    logic [47:0] src_addr;
    tas_pkg::tas_telegram_type telegram;
    logic [31:0] rx_ctr, rx_sig, signature_q, ctr_q;
    tas_pkg::tas_aes_req_type aes_req_q;
    tas_pkg::tas_aes_rsp_type aes_rsp;
    logic busy_q, done_q, match_q, comm_valid_q;
    logic [207:0] comm_payload_q;
    int bad_count, num_checks;
    logic [31:0] model_ctr, last_ctr; // Counter the device should use next, last used
    logic [127:0] cur_key; // Key the device should hold
    logic [32:0] exp_q[$]; // Expected {match, signature}
    logic [207:0] comm_q[$]; // Expected commissioning payloads
    logic [31:0] rx_best; // Highest counter a receiver has accepted
    logic rx_seen; // Receiver has accepted a telegram
    // Payload header: length, type, maker field; the maker field value is arbitrary
    localparam logic [31:0] hdr_ref = 32'h0CFF5A5A;

    tas_signer dut (.sys_clk(sys_clk), .reset(reset), .src_addr(src_addr),
        .telegram(telegram), .start_send(start_send), .start_repeat(start_repeat),
        .start_verify(start_verify), .rx_ctr(rx_ctr), .rx_sig(rx_sig),
        .commission_req(commission_req), .disable_commission(disable_commission),
        .key_wr_en(key_wr_en), .key_wr_idx(key_wr_idx), .key_wr_byte(key_wr_byte),
        .aes_rsp(aes_rsp), .aes_req_q(aes_req_q), .busy_q(busy_q), .done_q(done_q),
        .match_q(match_q), .signature_q(signature_q), .ctr_q(ctr_q),
        .comm_valid_q(comm_valid_q), .comm_payload_q(comm_payload_q));

    tas_cipher_model u_core (.sys_clk(sys_clk), .reset(reset), .slow(slow),
        .aes_req(aes_req_q), .aes_rsp(aes_rsp));

    // Byte reversal helpers for little-endian fields
    function automatic logic [31:0] le32(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction : le32

    function automatic logic [47:0] le48(input logic [47:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24], v[39:32], v[47:40]};
    endfunction : le48

    // Reference signature for the current address and telegram
    function automatic logic [31:0] sig_calc(input logic [31:0] c, input logic [127:0] k);
        logic [103:0] nonce;
        logic [127:0] b1;
        logic [127:0] t0;
        nonce = {le48(src_addr), le32(c), 24'h000000};
        b1 = {16'h0009, telegram.hdr, le32(c), telegram.status, 40'h0000000000};
        case (telegram.opt_size)
            2'h1: b1 = {16'h000A, b1[111:40], telegram.opt[31:24], 32'h00000000};
            2'h2: b1 = {16'h000B, b1[111:40], telegram.opt[31:16], 24'h000000};
            2'h3: b1 = {16'h000D, b1[111:40], telegram.opt, 8'h00};
            default: ;
        endcase
        t0 = tas_dv_pkg::cipher(tas_dv_pkg::cipher({8'h49, nonce, 16'h0000}, k) ^ b1, k)
            ^ tas_dv_pkg::cipher({8'h01, nonce, 16'h0000}, k);
        return t0[127:96];
    endfunction : sig_calc

    // Compare one value and count it
    task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Close the run with the counts and the verdict
    task automatic end_sim();
        check("queues_drained", 256'(exp_q.size() == 0 && comm_q.size() == 0), 256'h1);
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    // Launch a job at the current falling edge; kind 0 send, 1 repeat, 2 verify
    // A poke raises a verify strobe while busy, which must be ignored
    task automatic run_job(input int kind, input logic poke);
        int n;
        if (kind == 0) begin
            exp_q.push_back({1'b0, sig_calc(model_ctr, cur_key)});
            last_ctr = model_ctr;
            model_ctr = model_ctr + 32'h1;
        end else if (kind == 1) begin
            exp_q.push_back({1'b0, sig_calc(last_ctr, cur_key)});
        end
        start_send = (kind == 0);
        start_repeat = (kind == 1);
        start_verify = (kind == 2);
        @(negedge sys_clk);
        start_send = 1'b0;
        start_repeat = 1'b0;
        start_verify = poke;
        check("busy_q_run", busy_q, 1'b1);
        // Receiver side: a fresh counter passes, a repeat is a replay
        if (kind == 0) begin
            check("ctr_fresh", 256'(!rx_seen || (ctr_q - 32'h1) > rx_best), 256'h1);
            rx_best = ctr_q - 32'h1;
            rx_seen = 1'b1;
        end else if (kind == 1) begin
            check("replay_refused", 256'(rx_seen && last_ctr <= rx_best), 256'h1);
        end
        n = 0;
        while (done_q !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            start_verify = 1'b0;
            n++;
        end
        check("done_in_time", 256'(n < 100), 256'h1);
    endtask : run_job

    // Ask for a commissioning payload, blocked or not
    task automatic commission(input logic blocked);
        if (!blocked) begin
            comm_q.push_back({le32(model_ctr), cur_key, le48(src_addr)});
            model_ctr = model_ctr + 32'h1;
        end
        disable_commission = blocked;
        commission_req = 1'b1;
        @(negedge sys_clk);
        commission_req = 1'b0;
        repeat (6) @(negedge sys_clk);
        check("ctr_q", ctr_q, model_ctr);
    endtask : commission

    // Free-running system clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Watcher: every result takes the oldest expectation
    always @(negedge sys_clk) begin
        if (!reset && done_q === 1'b1) begin
            check("done_expected", 256'(exp_q.size() > 0), 256'h1);
            if (exp_q.size() > 0) begin
                check("signature_q", signature_q, exp_q[0][31:0]);
                check("match_q", match_q, exp_q[0][32]);
                void'(exp_q.pop_front());
            end
        end
        if (!reset && comm_valid_q === 1'b1) begin
            check("comm_expected", 256'(comm_q.size() > 0), 256'h1);
            if (comm_q.size() > 0) begin
                check("comm_payload_q", comm_payload_q, comm_q.pop_front());
            end
        end
    end

    // Watchdog sized far above the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        $display("[FAIL] watchdog expected finish seen hang");
        end_sim();
    end

    // Main sequence
    initial begin
        {slow, start_send, start_repeat, start_verify, commission_req} = '0;
        {disable_commission, key_wr_en, key_wr_idx, key_wr_byte} = '0;
        rx_ctr = 32'h00000000;
        rx_sig = 32'h00000000;
        telegram = '0;
        src_addr = 48'hE215000019B8;
        bad_count = 0;
        num_checks = 0;
        model_ctr = 32'h00000000;
        last_ctr = 32'h00000000;
        rx_best = 32'h00000000;
        rx_seen = 1'b0;
        cur_key = `TAS_KEY_RESET;
        void'($urandom(64179));
        reset = 1'b1;
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        check("ctr_q_reset", ctr_q, 32'h00000000);
        check("busy_q_reset", busy_q, 1'b0);
        check("key_reset", aes_req_q.key, `TAS_KEY_RESET);
        telegram = {hdr_ref, 8'($urandom()), 32'h00000000, 2'h0};
        run_job(0, 1'b0);
        // Load the reference key byte by byte, first byte at index 0
        for (int i = 0; i < 16; i++) begin
            key_wr_en = 1'b1;
            key_wr_idx = 4'(i);
            key_wr_byte = tas_dv_pkg::doc_key[127 - 8 * i -: 8];
            @(negedge sys_clk);
        end
        key_wr_en = 1'b0;
        repeat (3) @(negedge sys_clk);
        cur_key = tas_dv_pkg::doc_key;
        check("key_loaded", aes_req_q.key, tas_dv_pkg::doc_key);
        // Reference telegram: with src_addr, rx_ctr and the reference key it hits the three known cipher answers
        telegram = {hdr_ref, 8'h11, 32'h00000000, 2'h0};
        rx_ctr = 32'h0000045D;
        rx_sig = 32'hB2FA88FF;
        exp_q.push_back({1'b1, 32'hB2FA88FF});
        run_job(2, 1'b0);
        rx_sig = 32'hB2FA88FE;
        exp_q.push_back({1'b0, 32'hB2FA88FF});
        run_job(2, 1'b0);
        // Every optional size, slow core, send then repeat back to back
        slow = 1'b1;
        for (int s = 0; s < 4; s++) begin
            src_addr = {16'hE215, $urandom()};
            telegram = {$urandom(), 8'($urandom()), $urandom(), 2'(s)};
            run_job(0, 1'(s == 2));
            run_job(1, 1'b0);
        end
        check("ctr_q_after_sends", ctr_q, model_ctr);
        commission(1'b1);
        commission(1'b0);
        slow = 1'b0;
        // Reset in mid-run brings the counter back
        reset = 1'b1;
        @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        check("ctr_q_rereset", ctr_q, 32'h00000000);
        end_sim();
    end

endmodule : tas_signer_bench

`default_nettype wire

// file: hdl/tas_key_store.sv
// Purpose: Sixteen-byte secret key memory with registered read
// Assumes: Writes come from the near-field configuration logic
// Notes: Byte 0 sits in the top bits of the read word
`timescale 1ns/1ps
`default_nettype none
`include "tas_regs.svh"

module tas_key_store (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [7:0] wr_byte,
    output logic [127:0] key_q
);

    logic [7:0] mem_q [16];     // Key bytes
    logic [7:0] mem_d [16];     // Next key bytes
    logic [127:0] key_d;        // Next read word

    // Byte write and whole-key read word
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (wr_en) begin
            mem_d[wr_idx] = wr_byte;
        end
        for (int i = 0; i < 16; i++) begin
            key_d[127 - 8*i -: 8] = mem_q[i];
        end
    end

    // Reset loads the factory key; reads lag a write by one edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int i = 0; i < 16; i++) begin
                mem_q[i] <= 8'(`TAS_KEY_RESET >> (120 - 8*i));
            end
            key_q <= `TAS_KEY_RESET;
        end else begin
            mem_q <= mem_d;
            key_q <= key_d;
        end
    end

endmodule : tas_key_store
`default_nettype wire

// file: hdl/tas_pkg.sv
// Purpose: Types for the telegram authentication signature block
// Assumes: Constants live in tas_regs.svh
// Notes: Blocks are packed with the first-listed byte in the top bits
package tas_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        TAS_S_IDLE = 3'b000,
        TAS_S_MAC0 = 3'b001,
        TAS_S_MAC1 = 3'b010,
        TAS_S_CTR0 = 3'b011
    } tas_state_type;

    // Fields of the telegram to be signed or checked
    typedef struct packed {
        logic [31:0] hdr;       // Payload header bytes 0..3, byte 0 in top bits
        logic [7:0] status;     // Switch status byte
        logic [31:0] opt;       // Optional bytes, first byte in top bits
        logic [1:0] opt_size;   // Size code: 0, 1, 2 or 4 bytes
    } tas_telegram_type;

    // Request to the shared cipher core
    typedef struct packed {
        logic valid;            // Held high while an operation is wanted
        logic [127:0] block;    // Plain block
        logic [127:0] key;      // Cipher key
    } tas_aes_req_type;

    // Answer from the shared cipher core
    typedef struct packed {
        logic ack;              // One-cycle pulse, result valid
        logic [127:0] result;   // Cipher block
    } tas_aes_rsp_type;

endpackage : tas_pkg

// file: hdl/tas_regs.svh
// Purpose: Constants for the telegram authentication signature block
// Assumes: Included by bare name; definitions only
// Notes: Flags, lengths, reset values and field positions
`ifndef TAS_REGS_SVH
`define TAS_REGS_SVH

// Leading flag byte of the MAC block
`define TAS_MAC_FLAG 8'h49
// Leading flag byte of the counter block
`define TAS_CTR_FLAG 8'h01
// Encoded input length per optional data size
`define TAS_LEN_OPT0 16'h0009
`define TAS_LEN_OPT1 16'h000A
`define TAS_LEN_OPT2 16'h000B
`define TAS_LEN_OPT4 16'h000D
// Optional data size codes
`define TAS_OPT_NONE 2'h0
`define TAS_OPT_ONE 2'h1
`define TAS_OPT_TWO 2'h2
`define TAS_OPT_FOUR 2'h3
// Sequence counter value after reset
`define TAS_CTR_RESET 32'h00000000
// Key after reset; arbitrary value, stands in for the factory key
`define TAS_KEY_RESET 128'h00112233445566778899AABBCCDDEEFF
// Signature field: top four bytes of a 128-bit block
`define TAS_SIG_MSB 127
`define TAS_SIG_LSB 96

`endif

// file: hdl/tas_signer.sv
// Purpose: Builds and checks the 4-byte telegram signature, sequence
//          counter and key-revealing commissioning payload
// Assumes: All inputs come from logic on sys_clk; cipher core is outside
// Notes: One job at a time; requests are taken only while idle
`timescale 1ns/1ps
`default_nettype none
`include "tas_regs.svh"

module tas_signer (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [47:0] src_addr,
    input wire tas_pkg::tas_telegram_type telegram,
    input wire logic start_send,
    input wire logic start_repeat,
    input wire logic start_verify,
    input wire logic [31:0] rx_ctr,
    input wire logic [31:0] rx_sig,
    input wire logic commission_req,
    input wire logic disable_commission,
    input wire logic key_wr_en,
    input wire logic [3:0] key_wr_idx,
    input wire logic [7:0] key_wr_byte,
    input wire tas_pkg::tas_aes_rsp_type aes_rsp,
    output tas_pkg::tas_aes_req_type aes_req_q,
    output logic busy_q,
    output logic done_q,
    output logic match_q,
    output logic [31:0] signature_q,
    output logic [31:0] ctr_q,
    output logic comm_valid_q,
    output logic [207:0] comm_payload_q
);

    // Byte swap of a 48-bit address into transmit order
    function automatic logic [47:0] le48(input logic [47:0] v);
        for (int i = 0; i < 6; i++) begin
            le48[47 - 8*i -: 8] = v[8*i +: 8];
        end
    endfunction : le48

    // Byte swap of a 32-bit counter into transmit order
    function automatic logic [31:0] le32(input logic [31:0] v);
        for (int i = 0; i < 4; i++) begin
            le32[31 - 8*i -: 8] = v[8*i +: 8];
        end
    endfunction : le32

    // Encoded input length for a size code; every code is legal
    function automatic logic [15:0] in_len(input logic [1:0] size);
        case (size)
            `TAS_OPT_NONE: in_len = `TAS_LEN_OPT0;
            `TAS_OPT_ONE: in_len = `TAS_LEN_OPT1;
            `TAS_OPT_TWO: in_len = `TAS_LEN_OPT2;
            default: in_len = `TAS_LEN_OPT4;
        endcase
    endfunction : in_len

    // Nonce: address, counter, three zero bytes
    function automatic logic [103:0] nonce(input logic [47:0] a, input logic [31:0] c);
        nonce = {le48(a), le32(c), 24'h000000};
    endfunction : nonce

    // Second MAC block: length, input data, zero fill
    function automatic logic [127:0] build_b1(input tas_pkg::tas_telegram_type t,
                                              input logic [31:0] c);
        logic [31:0] opt;
        case (t.opt_size)
            `TAS_OPT_NONE: opt = 32'h00000000;
            `TAS_OPT_ONE: opt = {t.opt[31:24], 24'h000000};
            `TAS_OPT_TWO: opt = {t.opt[31:16], 16'h0000};
            default: opt = t.opt;
        endcase
        // Unused optional bytes double as padding
        build_b1 = {in_len(t.opt_size), t.hdr, le32(c), t.status, opt, 8'h00};
    endfunction : build_b1

    logic [127:0] key_rd;                       // Current key, registered in store
    tas_pkg::tas_state_type state_q, state_d;   // Sequencer state
    logic [47:0] addr_q, addr_d;                // Address latched for the job
    logic [31:0] job_ctr_q, job_ctr_d;          // Counter used by the job
    logic [127:0] b1_q, b1_d;                   // Second MAC block
    logic [127:0] x2_q, x2_d;                   // MAC chain result
    logic verify_q, verify_d;                   // Job checks a received signature
    logic [31:0] rx_sig_q, rx_sig_d;            // Received signature
    logic [31:0] ctr_d;                         // Next device counter
    tas_pkg::tas_aes_req_type aes_req_d;        // Next cipher request
    logic busy_d, done_d, match_d, comm_valid_d;
    logic [31:0] signature_d;
    logic [207:0] comm_payload_d;
    logic launch;                               // A signing job starts now

    // Key lives in its own memory; written by the configuration port
    tas_key_store u_key_store (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_en(key_wr_en),
        .wr_idx(key_wr_idx),
        .wr_byte(key_wr_byte),
        .key_q(key_rd)
    );

    // Sequencer: three cipher passes on one shared core
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        job_ctr_d = job_ctr_q;
        b1_d = b1_q;
        x2_d = x2_q;
        verify_d = verify_q;
        rx_sig_d = rx_sig_q;
        ctr_d = ctr_q;
        aes_req_d = aes_req_q;
        aes_req_d.key = key_rd;
        done_d = 1'b0;
        match_d = match_q;
        signature_d = signature_q;
        comm_valid_d = 1'b0;
        comm_payload_d = comm_payload_q;
        launch = 1'b0;
        case (state_q)
            tas_pkg::TAS_S_IDLE: begin
                // Fixed priority: send, repeat, verify, commissioning
                if (start_send) begin
                    job_ctr_d = ctr_q;
                    ctr_d = ctr_q + 32'h00000001;
                    verify_d = 1'b0;
                    launch = 1'b1;
                end else if (start_repeat) begin
                    // Same counter again, so the signature repeats too
                    verify_d = 1'b0;
                    launch = 1'b1;
                end else if (start_verify) begin
                    job_ctr_d = rx_ctr;
                    rx_sig_d = rx_sig;
                    verify_d = 1'b1;
                    launch = 1'b1;
                end else if (commission_req && !disable_commission) begin
                    comm_valid_d = 1'b1;
                    comm_payload_d = {le32(ctr_q), key_rd, le48(src_addr)};
                    ctr_d = ctr_q + 32'h00000001;
                end
                if (launch) begin
                    addr_d = src_addr;
                    b1_d = build_b1(telegram, job_ctr_d);
                    match_d = 1'b0;
                    aes_req_d.valid = 1'b1;
                    aes_req_d.block = {`TAS_MAC_FLAG, nonce(src_addr, job_ctr_d), 16'h0000};
                    state_d = tas_pkg::TAS_S_MAC0;
                end
            end
            tas_pkg::TAS_S_MAC0: begin
                // X1 arrives; chain it into the second block
                if (aes_rsp.ack) begin
                    aes_req_d.block = aes_rsp.result ^ b1_q;
                    state_d = tas_pkg::TAS_S_MAC1;
                end
            end
            tas_pkg::TAS_S_MAC1: begin
                // X2 arrives; encrypt the counter block next
                if (aes_rsp.ack) begin
                    x2_d = aes_rsp.result;
                    aes_req_d.block = {`TAS_CTR_FLAG, nonce(addr_q, job_ctr_q), 16'h0000};
                    state_d = tas_pkg::TAS_S_CTR0;
                end
            end
            tas_pkg::TAS_S_CTR0: begin
                // S0 arrives; T0 = X2 xor S0, keep its first four bytes
                if (aes_rsp.ack) begin
                    signature_d = x2_q[`TAS_SIG_MSB:`TAS_SIG_LSB]
                                ^ aes_rsp.result[`TAS_SIG_MSB:`TAS_SIG_LSB];
                    match_d = verify_q && (signature_d == rx_sig_q);
                    done_d = 1'b1;
                    aes_req_d.valid = 1'b0;
                    state_d = tas_pkg::TAS_S_IDLE;
                end
            end
            default: begin
                aes_req_d.valid = 1'b0;
                state_d = tas_pkg::TAS_S_IDLE;
            end
        endcase
        busy_d = (state_d != tas_pkg::TAS_S_IDLE);
    end

    // Registers; counter clears only with reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= tas_pkg::TAS_S_IDLE;
            addr_q <= 48'h000000000000;
            job_ctr_q <= `TAS_CTR_RESET;
            b1_q <= 128'h0;
            x2_q <= 128'h0;
            verify_q <= 1'b0;
            rx_sig_q <= 32'h00000000;
            ctr_q <= `TAS_CTR_RESET;
            aes_req_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            match_q <= 1'b0;
            signature_q <= 32'h00000000;
            comm_valid_q <= 1'b0;
            comm_payload_q <= '0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            job_ctr_q <= job_ctr_d;
            b1_q <= b1_d;
            x2_q <= x2_d;
            verify_q <= verify_d;
            rx_sig_q <= rx_sig_d;
            ctr_q <= ctr_d;
            aes_req_q <= aes_req_d;
            busy_q <= busy_d;
            done_q <= done_d;
            match_q <= match_d;
            signature_q <= signature_d;
            comm_valid_q <= comm_valid_d;
            comm_payload_q <= comm_payload_d;
        end
    end

    // Checks on the built blocks and the result path
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    a_mac_block_form: assert property (
        (state_q == tas_pkg::TAS_S_MAC0) |-> (aes_req_q.block[127:120] == `TAS_MAC_FLAG)
            && (aes_req_q.block[15:0] == 16'h0000) && aes_req_q.valid)
        else $error("MAC block flag or tail wrong");

    a_ctr_block_form: assert property (
        (state_q == tas_pkg::TAS_S_CTR0) |-> (aes_req_q.block[127:120] == `TAS_CTR_FLAG)
            && (aes_req_q.block[119:16] == nonce(addr_q, job_ctr_q)))
        else $error("Counter block wrong");

    a_nonce_order: assert property (
        (state_q == tas_pkg::TAS_S_MAC0) |-> (aes_req_q.block[119:72] == le48(addr_q))
            && (aes_req_q.block[71:40] == le32(job_ctr_q)) && (aes_req_q.block[39:16] == 24'h0))
        else $error("Nonce layout wrong");

    a_len_field: assert property (
        (state_q != tas_pkg::TAS_S_IDLE) |-> (b1_q[127:112] == `TAS_LEN_OPT0)
            || (b1_q[127:112] == `TAS_LEN_OPT1) || (b1_q[127:112] == `TAS_LEN_OPT2)
            || (b1_q[127:112] == `TAS_LEN_OPT4))
        else $error("Length field out of set");

    a_ctr_bytes: assert property (
        (state_q != tas_pkg::TAS_S_IDLE) |-> (b1_q[79:48] == le32(job_ctr_q)))
        else $error("Counter not at input bytes 4..7");

    a_ctr_advance: assert property (
        (state_q == tas_pkg::TAS_S_IDLE) && start_send |=> (ctr_q == $past(ctr_q) + 32'h1)
            && (job_ctr_q == $past(ctr_q)))
        else $error("Counter did not step once");

    a_repeat_same: assert property (
        (state_q == tas_pkg::TAS_S_IDLE) && !start_send && start_repeat
            |=> (job_ctr_q == $past(job_ctr_q)) && (ctr_q == $past(ctr_q)))
        else $error("Repeat changed the counter");

    a_sig_from_t0: assert property (
        (state_q == tas_pkg::TAS_S_CTR0) && aes_rsp.ack |=> done_q && !busy_q
            && (signature_q == ($past(x2_q[127:96]) ^ $past(aes_rsp.result[127:96]))))
        else $error("Signature not T0 head");

    a_match_flag: assert property (
        done_q |-> (match_q == (verify_q && (signature_q == rx_sig_q))))
        else $error("Match flag wrong");

    a_comm_blocked: assert property (
        (state_q == tas_pkg::TAS_S_IDLE) && disable_commission |=> !comm_valid_q)
        else $error("Commissioning sent while disabled");

    a_comm_payload: assert property (
        comm_valid_q |-> (comm_payload_q[207:176] == le32($past(ctr_q)))
            && (comm_payload_q[175:48] == $past(key_rd)))
        else $error("Commissioning payload wrong");

    a_key_write: assert property (
        key_wr_en ##1 !key_wr_en |-> ##1 (key_rd[127 - 8*$past(key_wr_idx, 2) -: 8]
            == $past(key_wr_byte, 2)))
        else $error("Key byte not stored");

    c_send_done: cover property (start_send && !busy_q ##[1:50] done_q);
    c_verify_match: cover property (done_q && match_q);
    c_commission: cover property (comm_valid_q);
    c_repeat_done: cover property (start_repeat && !start_send && !busy_q ##[1:50] done_q);

endmodule : tas_signer
`default_nettype wire
